/* design/rcsl_clk_select.v */
// rcsl_clk_select.v: picks the system clock source when a reset ends
// assumes: one-cycle reset-type pulses and config levels on the same clock
`timescale 1ns/1ps
`default_nettype none
module rcsl_clk_select (
  input  wire       clk,
  input  wire       rstN,
  input  wire       porEvt,
  input  wire       borEvt,
  input  wire       warmEvt,
  input  wire       clkSwitchEn,
  input  wire [2:0] oscConfigField,
  input  wire [2:0] currentOscField,
  output reg  [2:0] clkSource
);
  // source latched at each reset; fuse value after a power-on
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      clkSource <= 3'h0;
    end else if (porEvt || borEvt) begin
      clkSource <= oscConfigField;
    end else if (warmEvt) begin
      clkSource <= clkSwitchEn ? currentOscField : oscConfigField;
    end
  end
endmodule // rcsl_clk_select
`default_nettype wire

/* design/rcsl_reset_cause.v */
// rcsl_reset_cause.v: reset-cause and power-state status register with axi4-lite access
// assumes: event inputs are asynchronous levels or pulses held at least three clocks;
// the power-on event is also signalled as porEvtIn after nrst releases.
//
// What this block does
// - deep-sleep flag set by sleep with enable
// - config mismatch reset sets bit nine
// - bit eight keeps program memory bias
// - pin reset sets bit seven
// - illegal opcode or pointer sets bit 14
// - watchdog on by bit or fuse
// - sleep instruction sets sleep flag
// - idle instruction sets idle flag
// - brown-out or power-on sets bit one
// - power-on sets bit zero
// - software writes never cause a reset
// - software may set or clear flags
// - switching on: cold fuses, warm current
// - switching off: always fuses
// - power-on clears all but bits 1:0
`timescale 1ns/1ps
`include "rcsl_defs.vh"
`default_nettype none
module rcsl_reset_cause (
  input  wire        ref_clk,
  input  wire        nrst,
  // asynchronous event levels from the reset and power controller
  input  wire        porEvtIn,
  input  wire        borEvtIn,
  input  wire        pinResetIn,
  input  wire        softResetIn,
  input  wire        watchdogTimeoutIn,
  input  wire        trapConflictIn,
  input  wire        illegalAccessIn,
  input  wire        configMismatchIn,
  input  wire        sleepInstrIn,
  input  wire        idleInstrIn,
  input  wire        deepSleepEnable,
  input  wire        sleepActive,
  input  wire        watchdogConfigFuse,
  input  wire        clkSwitchEn,
  input  wire [2:0]  oscConfigField,
  input  wire [2:0]  currentOscField,
  // axi4-lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // block outputs
  output reg         watchdogEnable,
  output reg         progmemBiasOn,
  output reg  [2:0]  clkSource,
  output reg         irq
);
  // reset release synchroniser
  reg  rstMeta_q;
  reg  rstN_q;
  wire rstN = rstN_q;

  // asynchronous assert, two-flop release
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstN_q    <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN_q    <= rstMeta_q;
    end
  end

  // synchronised event levels and their previous values
  wire [9:0]  evtSync;
  reg  [9:0]  evtPrev_q;
  wire [9:0]  evtRise = evtSync & ~evtPrev_q;
  wire        deepEnSync;
  wire        wdtFuseSync;
  wire        sleepSync;

  // event, enable, fuse and sleep levels pass two flops; the clock config levels go straight to uClk
  rcsl_sync2 #(.W(13)) uSync (
    .clk  (ref_clk),
    .rstN (rstN),
    .din  ({sleepActive, watchdogConfigFuse, deepSleepEnable, idleInstrIn,
            sleepInstrIn, configMismatchIn, illegalAccessIn, trapConflictIn,
            watchdogTimeoutIn, softResetIn, pinResetIn, borEvtIn, porEvtIn}),
    .dout ({sleepSync, wdtFuseSync, deepEnSync, evtSync})
  );

  // latency: an event level reaches the edge detector two clocks after it
  // rises and lands in the cause register on the third edge; a pulse shorter
  // than that can slip between samples and be lost, so the controller must
  // hold each level for at least three clocks.
  // the enable, fuse and sleep levels share the same two-stage delay, which
  // keeps deep-sleep enable lined up with the sleep event edge that it
  // qualifies.

  // edge memory for one-cycle event pulses
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      evtPrev_q <= 10'h000;
    end else begin
      evtPrev_q <= evtSync;
    end
  end

  // named event pulses
  wire porEvt   = evtRise[0];
  wire borEvt   = evtRise[1];
  wire pinEvt   = evtRise[2];
  wire softEvt  = evtRise[3];
  wire wdogToEvt = evtRise[4];
  wire trapEvt  = evtRise[5];
  wire illEvt   = evtRise[6];
  wire cfgEvt   = evtRise[7];
  wire sleepEvt = evtRise[8];
  wire idleEvt  = evtRise[9];

  // byte-lane merge of a write into the low halfword
  function [15:0] laneMerge;
    input [15:0] old;
    input [15:0] newv;
    input [1:0]  strb;
    begin
      laneMerge = {strb[1] ? newv[15:8] : old[15:8], strb[0] ? newv[7:0] : old[7:0]};
    end
  endfunction

  // axi write channel capture: address and data taken in either order
  reg [3:0]  wrAddr_q;
  reg [31:0] wrData_q;
  reg [3:0]  wrStrb_q;
  reg        haveAw_q;
  reg        haveW_q;
  wire       wrFire = haveAw_q && haveW_q && !s_axi_bvalid;

  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      haveAw_q      <= 1'b0;
      haveW_q       <= 1'b0;
      wrAddr_q      <= 4'h0;
      wrData_q      <= 32'h0000_0000;
      wrStrb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RCSL_RESP_OKAY;
    end else begin
      // ready offered only while the slot is empty
      s_axi_awready <= !haveAw_q && !s_axi_awready;
      s_axi_wready  <= !haveW_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw_q <= 1'b1;
        wrAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW_q  <= 1'b1;
        wrData_q <= s_axi_wdata;
        wrStrb_q <= s_axi_wstrb;
      end
      // response follows both halves
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrAddr_q == `RCSL_ADDR_IRQSTAT) ? `RCSL_RESP_SLVERR :
                        (wrAddr_q[1:0] != 2'h0) ? `RCSL_RESP_SLVERR : `RCSL_RESP_OKAY;
        haveAw_q     <= 1'b0;
        haveW_q      <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wrCause = wrFire && (wrAddr_q == `RCSL_ADDR_CAUSE);
  wire wrClr   = wrFire && (wrAddr_q == `RCSL_ADDR_IRQCLR);
  wire wrEn    = wrFire && (wrAddr_q == `RCSL_ADDR_IRQEN);

  // reset cause register
  reg  [15:0] cause_q;
  reg  [15:0] cause_d;
  reg  [15:0] swVal;

  // software write first, hardware events override so a write never drops a hardware set; a power-on event replaces the whole value
  always @* begin
    swVal   = laneMerge(cause_q, wrData_q[15:0], wrStrb_q[1:0]);
    cause_d = cause_q;
    if (wrCause) begin
      cause_d = swVal & `RCSL_CAUSE_MASK;
    end
    if (sleepEvt || idleEvt) begin
      cause_d[`RCSL_B_WDOG_TO] = 1'b0;
    end
    if (illEvt) cause_d[`RCSL_B_ILLEGAL] = 1'b1;
    if (trapEvt) cause_d[`RCSL_B_TRAP] = 1'b1;
    if (cfgEvt) cause_d[`RCSL_B_CFGMIS] = 1'b1;
    if (pinEvt) cause_d[`RCSL_B_PIN] = 1'b1;
    // software reset instruction flag
    if (softEvt) cause_d[`RCSL_B_SOFT] = 1'b1;
    if (wdogToEvt) cause_d[`RCSL_B_WDOG_TO] = 1'b1;
    if (sleepEvt) cause_d[`RCSL_B_SLEEP] = 1'b1;
    if (sleepEvt && deepEnSync) cause_d[`RCSL_B_DEEPSLP] = 1'b1;
    if (idleEvt) cause_d[`RCSL_B_IDLE] = 1'b1;
    if (borEvt) cause_d[`RCSL_B_BOR] = 1'b1;
    if (porEvt) cause_d = `RCSL_CAUSE_POR;
  end

  // cause register state; async reset is the power-on image
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      cause_q <= `RCSL_CAUSE_POR;
    end else begin
      cause_q <= cause_d;
    end
  end

  // interrupt status: one sticky bit per event group
  wire [3:0] irqEvt = {sleepEvt | idleEvt, wdogToEvt, trapEvt | illEvt | cfgEvt,
                       pinEvt | softEvt | borEvt | porEvt};
  reg  [3:0] irqStat_q;
  reg  [3:0] irqEn_q;
  genvar gi;

  // one sticky bit per event group, set wins over clear
  generate
    for (gi = 0; gi < `RCSL_NEVT; gi = gi + 1) begin : gIrq
      always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
          irqStat_q[gi] <= 1'b0;
        end else if (irqEvt[gi]) begin
          irqStat_q[gi] <= 1'b1;
        end else if (wrClr && wrStrb_q[0] && wrData_q[gi]) begin
          irqStat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // enable register and level interrupt
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      irqEn_q <= 4'h0;
      irq     <= 1'b0;
    end else begin
      if (wrEn && wrStrb_q[0]) begin
        irqEn_q <= wrData_q[3:0];
      end
      irq <= |(irqStat_q & irqEn_q);
    end
  end

  // block outputs from flops
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      watchdogEnable <= 1'b0;
      progmemBiasOn  <= 1'b1;
    end else begin
      watchdogEnable <= cause_q[`RCSL_B_WDOGEN] | wdtFuseSync;
      // bias kept or dropped in sleep
      progmemBiasOn  <= !sleepSync | cause_q[`RCSL_B_PMPWR];
    end
  end

  // clock source choice at reset
  wire [2:0] clkSel;
  rcsl_clk_select uClk (
    .clk             (ref_clk),
    .rstN            (rstN),
    .porEvt          (porEvt),
    .borEvt          (borEvt),
    .warmEvt         (pinEvt | wdogToEvt | softEvt),
    .clkSwitchEn     (clkSwitchEn),
    .oscConfigField  (oscConfigField),
    .currentOscField (currentOscField),
    .clkSource       (clkSel)
  );

  // registered copy so the port comes straight from a flop
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      clkSource <= 3'h0;
    end else begin
      clkSource <= clkSel;
    end
  end

  // read channel: one read at a time, answer one cycle after the address
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RCSL_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RCSL_RESP_OKAY;
        case (s_axi_araddr)
          `RCSL_ADDR_CAUSE:   s_axi_rdata <= {16'h0000, cause_q};
          `RCSL_ADDR_IRQSTAT: s_axi_rdata <= {28'h0000000, irqStat_q};
          `RCSL_ADDR_IRQCLR:  s_axi_rdata <= 32'h0000_0000;
          `RCSL_ADDR_IRQEN:   s_axi_rdata <= {28'h0000000, irqEn_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RCSL_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // rcsl_reset_cause
`default_nettype wire

/* design/rcsl_sync2.v */
// rcsl_sync2.v: two-flop synchroniser for a vector of asynchronous levels
// assumes: inputs come from outside the clock domain; rstN is already synchronous-release
`timescale 1ns/1ps
`default_nettype none
module rcsl_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rstN,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_q; // first stage, read only by the second

  // two flip-flops before any logic sees the level
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // rcsl_sync2
`default_nettype wire

/* inc/rcsl_defs.vh */
// rcsl_defs.vh: offsets, field positions, reset values for the reset cause block
// assumes: included by bare name from design files under design/
`ifndef RCSL_DEFS_VH
`define RCSL_DEFS_VH
// register byte addresses (axi4-lite, one aligned word each)
`define RCSL_ADDR_CAUSE     4'h0
`define RCSL_ADDR_IRQSTAT   4'h4
`define RCSL_ADDR_IRQCLR    4'h8
`define RCSL_ADDR_IRQEN     4'hc
`define RCSL_ADDR_CLKSEL    4'h0
// cause register bit positions
`define RCSL_B_TRAP     15
`define RCSL_B_ILLEGAL  14
`define RCSL_B_DEEPSLP  10
`define RCSL_B_CFGMIS   9
`define RCSL_B_PMPWR    8
`define RCSL_B_PIN      7
`define RCSL_B_SOFT     6
`define RCSL_B_WDOGEN   5
`define RCSL_B_WDOG_TO  4
`define RCSL_B_SLEEP    3
`define RCSL_B_IDLE     2
`define RCSL_B_BOR      1
`define RCSL_B_POR      0
// implemented bits, 13:11 read as zero
`define RCSL_CAUSE_MASK  16'hc7ff
// value after a power-on reset: brown-out and power-on flags set
`define RCSL_CAUSE_POR   16'h0003
// interrupt event count
`define RCSL_NEVT        4
// axi responses
`define RCSL_RESP_OKAY   2'h0
`define RCSL_RESP_SLVERR 2'h2
`endif

/* verification/rcsl_reset_cause_assertions.sv */
// rcsl_reset_cause_assertions.sv: port-level checks for the reset cause block
// assumes: bound into rcsl_reset_cause, one ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module rcsl_reset_cause_assertions (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        sleepActive,
  input wire logic        watchdogConfigFuse,
  input wire logic        clkSwitchEn,
  input wire logic [2:0]  oscConfigField,
  input wire logic [2:0]  currentOscField,
  input wire logic        borEvtIn,
  input wire logic        pinResetIn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        watchdogEnable,
  input wire logic        progmemBiasOn,
  input wire logic [2:0]  clkSource
);
  // settle counter: the synchronisers are still filling just after reset
  logic [3:0] upCnt_q;
  wire        live = upCnt_q[3];
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst) upCnt_q <= 4'h0;
    else if (!live) upCnt_q <= upCnt_q + 4'h1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_fuse_forces_wdog: assert property (
    (live && watchdogConfigFuse)[*4] |-> watchdogEnable) else $error("fuse not forcing watchdog");
  a_awake_bias_on: assert property (
    (live && !sleepActive)[*5] |-> progmemBiasOn) else $error("bias off while awake");
  a_warm_current: assert property (
    live && $rose(pinResetIn) && clkSwitchEn |-> ##[2:10] clkSource == currentOscField)
    else $error("warm reset source wrong");
  a_cold_config: assert property (
    live && $rose(borEvtIn) |-> ##[2:10] clkSource == oscConfigField)
    else $error("cold reset source wrong");
  a_fixed_source: assert property (
    live && $rose(pinResetIn) && !clkSwitchEn |-> ##[2:10] clkSource == oscConfigField)
    else $error("fixed source not taken");
  a_read_answer: assert property (rdTaken |=> s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (wrTaken |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_clear_reads_zero: assert property (
    rdTaken ##0 s_axi_araddr == 4'h8 |=> s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0)
    else $error("clear register read not zero");
  a_cause_gaps_zero: assert property (
    rdTaken ##0 s_axi_araddr == 4'h0 |=> (s_axi_rdata & 32'hffff3800) == 32'h0)
    else $error("unused cause bits set");
endmodule // rcsl_reset_cause_assertions
bind rcsl_reset_cause rcsl_reset_cause_assertions chk_u (.*);
`default_nettype wire

/* verification/testbench.sv */
// testbench.sv: self-checking bench for the reset cause block
// assumes: rcsl_defs.vh on the include path, checker bound separately
`timescale 1ns/1ps
`include "rcsl_defs.vh"
`default_nettype none
module testbench;
  logic        ref_clk, nrst;
  logic [9:0]  evt;  // por bor pin soft watchdog_timeout_flag trap illegal cfg sleep idle
  logic        deepSleepEnable, sleepActive, watchdogConfigFuse, clkSwitchEn;
  logic [2:0]  oscConfigField, currentOscField;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         watchdogEnable, progmemBiasOn, irq;
  wire  [2:0]  clkSource;
  int          errTotal = 0, checked = 0, cyc = 0;
  int          bitOf [10] = '{0, 1, 7, 6, 4, 15, 14, 9, 3, 2};
  rcsl_reset_cause dut_u (.*, .porEvtIn(evt[0]), .borEvtIn(evt[1]), .pinResetIn(evt[2]),
    .softResetIn(evt[3]), .watchdogTimeoutIn(evt[4]), .trapConflictIn(evt[5]),
    .illegalAccessIn(evt[6]), .configMismatchIn(evt[7]), .sleepInstrIn(evt[8]),
    .idleInstrIn(evt[9]));
  initial begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic results;
    if (errTotal == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard: whole run needs well under this many clocks
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errTotal++;
      results;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic ad, dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ad && dd)) begin
      @(posedge ref_clk);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 0;
      end
      if (!dd && s_axi_wready) begin
        dd = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge ref_clk);
  endtask
  // read: rready raised one clock late so the slave has to hold its answer
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    @(posedge ref_clk);
    s_axi_rready <= 1;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge ref_clk);
  endtask
  // event level held four clocks, longer than the synchroniser needs
  task automatic evp(input int i);
    evt[i] <= 1;
    repeat (4) @(posedge ref_clk);
    evt[i] <= 0;
    repeat (10) @(posedge ref_clk);
  endtask
  function automatic logic [31:0] causeOf(input int i);
    causeOf = (i == 0) ? 32'h3 : 32'h1 << bitOf[i];
  endfunction
  // cold events take the fuse field; warm ones the current field if switching
  function automatic logic [2:0] srcOf(input int i, input logic sw,
                                       input logic [2:0] oc, cc, old);
    if (i <= 1 || (i <= 4 && !sw)) srcOf = oc;
    else if (i <= 4) srcOf = cc;
    else srcOf = old;
  endfunction
  initial begin
    int          i;
    logic [31:0] d, v;
    logic [1:0]  r;
    logic [2:0]  eSrc;
    {nrst, evt, deepSleepEnable, sleepActive, watchdogConfigFuse, clkSwitchEn} = '0;
    {oscConfigField, currentOscField, s_axi_awaddr, s_axi_wstrb, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    v = $urandom(32'h3ae1);
    eSrc = 3'h0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1;
    repeat (6) @(posedge ref_clk);
    rd(4'h0, d, r);
    chk(d, 32'h3);
    for (int k = 0; k < 18; k++) begin
      i = 1 + k % 9;
      v = $urandom;
      // switching on for the first pass, off for the second: warm resets hit both
      v[3] = k < 9;
      clkSwitchEn <= v[3];
      oscConfigField <= v[2:0];
      currentOscField <= ~v[2:0];
      wr(4'h0, 32'h0, 4'h3, r);
      eSrc = srcOf(i, v[3], v[2:0], ~v[2:0], eSrc);
      evp(i);
      rd(4'h0, d, r);
      chk(d, causeOf(i));
      chk(clkSource, eSrc);
    end
    evp(4);
    evp(9);
    rd(4'h0, d, r);
    chk(d, 32'h4);
    deepSleepEnable <= 1;
    evp(8);
    deepSleepEnable <= 0;
    rd(4'h0, d, r);
    chk(d[10], 1'b1);
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 32'hffffffff : $urandom;
      wr(4'h0, v, 4'h3, r);
      rd(4'h0, d, r);
      chk(d, v & 32'hc7ff);
    end
    wr(4'h0, 32'h20, 4'h3, r);
    repeat (5) @(posedge ref_clk);
    chk(watchdogEnable, 1'b1);
    wr(4'h0, 32'h0, 4'h3, r);
    repeat (2) @(posedge ref_clk);
    chk(watchdogEnable, 1'b0);
    watchdogConfigFuse <= 1;
    sleepActive <= 1;
    repeat (5) @(posedge ref_clk);
    chk(watchdogEnable, 1'b1);
    chk(progmemBiasOn, 1'b0);
    wr(4'h0, 32'h100, 4'h3, r);
    repeat (5) @(posedge ref_clk);
    chk(progmemBiasOn, 1'b1);
    sleepActive <= 0;
    watchdogConfigFuse <= 0;
    // interrupt: raised while masked, then enabled, then cleared
    wr(4'hc, 32'h0, 4'h1, r);
    wr(4'h8, 32'hf, 4'h1, r);
    evp(5);
    rd(4'h4, d, r);
    chk(d, 32'h2);
    chk(irq, 1'b0);
    wr(4'hc, 32'h2, 4'h1, r);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b1);
    wr(4'h8, 32'h2, 4'h1, r);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0);
    wr(4'h4, 32'h1, 4'h1, r);
    chk(r, `RCSL_RESP_SLVERR);
    rd(4'h8, d, r);
    chk(d, 32'h0);
    // unmapped offset answers with an error and zero data
    rd(4'h2, d, r);
    chk(r, `RCSL_RESP_SLVERR);
    chk(d, 32'h0);
    // power-on event over a busy register
    evp(0);
    rd(4'h0, d, r);
    chk(d, 32'h3);
    results;
  end
endmodule // testbench
`default_nettype wire
